// ### include/pfdc_pkg.sv
// package: register map, field positions and reset values of the parallel fifo dma control block
package pfdc_pkg;
    // ************************************************************
    // register byte addresses (index * 4, since 0x31 is not word aligned)
    // ************************************************************
    localparam logic [7:0] PFDC_IDX_FIFO_CONTROL = 8'h31;
    localparam logic [7:0] PFDC_IDX_CHANNEL_RESET = 8'h6C;
    localparam logic [7:0] PFDC_IDX_AUX_CONTROL = 8'h3F;
    localparam logic [7:0] PFDC_IDX_FIFO_QUANTITY = 8'h3A;
    localparam logic [7:0] PFDC_IDX_FIFO_THRESHOLD = 8'h3B;
    localparam logic [7:0] PFDC_IDX_STATUS = 8'h70;
    localparam logic [9:0] PFDC_ADDR_FIFO_CONTROL = {PFDC_IDX_FIFO_CONTROL, 2'b00};
    localparam logic [9:0] PFDC_ADDR_CHANNEL_RESET = {PFDC_IDX_CHANNEL_RESET, 2'b00};
    localparam logic [9:0] PFDC_ADDR_AUX_CONTROL = {PFDC_IDX_AUX_CONTROL, 2'b00};
    localparam logic [9:0] PFDC_ADDR_FIFO_QUANTITY = {PFDC_IDX_FIFO_QUANTITY, 2'b00};
    localparam logic [9:0] PFDC_ADDR_FIFO_THRESHOLD = {PFDC_IDX_FIFO_THRESHOLD, 2'b00};
    localparam logic [9:0] PFDC_ADDR_STATUS = {PFDC_IDX_STATUS, 2'b00};
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PFDC_BIT_FIFO_FLUSH = 7;
    localparam int PFDC_BIT_REQ_ENABLE = 6;
    localparam int PFDC_BIT_DIRECTION = 5;
    localparam int PFDC_BIT_SOFT_RESET = 0;
    localparam int PFDC_BIT_ACK_SYNC = 1;
    localparam int PFDC_BIT_UNFAIR = 0;
    // ************************************************************
    // reset values and masks
    // ************************************************************
    localparam logic [7:0] PFDC_RST_FIFO_CONTROL = 8'h00;
    localparam logic [7:0] PFDC_RST_CHANNEL_RESET = 8'h00;
    localparam logic [7:0] PFDC_RST_AUX_CONTROL = 8'h00;
    localparam logic [6:0] PFDC_RST_THRESHOLD = 7'h00;
    localparam logic [7:0] PFDC_MASK_CHANNEL_RESET = 8'h01;
    localparam logic [7:0] PFDC_MASK_AUX_CONTROL = 8'hFB;
    localparam logic [7:0] PFDC_CMD_HARD_RESET = 8'h81;
    localparam logic [6:0] PFDC_WORD_BYTES = 7'h02;
endpackage : pfdc_pkg

// ### rtl/pfdc_top.sv
// module: apb register slave, transfer request logic and fair-share override of the parallel fifo channel
`timescale 1ns/10ps
module pfdc_top
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [6:0] fifo_level_i,
    input wire logic [7:0] channel_command_i,
    input wire logic channel_command_valid_i,
    input wire logic transfer_grant_n_i,
    input wire logic [1:0] serial_svc_pending_i,
    input wire logic [1:0] serial_svc_line_n_i,
    output logic transfer_request_n_o,
    output logic transfer_grant_o,
    output logic transfer_direction_o,
    output logic fifo_flush_o,
    output logic channel_reset_o,
    output logic [1:0] serial_svc_req_n_o
);
    import pfdc_pkg::*;

    // ************************************************************
    // apb decode
    // ************************************************************
    logic setup_q;
    logic [7:0] fifo_control_q;
    logic [7:0] channel_reset_q;
    logic [7:0] aux_control_q;
    logic [6:0] threshold_q;
    logic [6:0] quantity_q;
    logic [2:0] grant_sync_q;
    logic grant_d;
    logic [2:0] line0_sync_q;
    logic [2:0] line1_sync_q;
    logic [1:0] line_busy_q;
    logic wr_fire;
    logic rd_fire;
    logic hard_clear;
    logic chan_rst;
    logic [7:0] wbyte;
    logic mapped;

    function automatic logic addr_hit(input logic [31:0] a, input logic [9:0] reg_addr);
        addr_hit = (a[31:10] == 22'h000000) && (a[9:0] == reg_addr);
    endfunction : addr_hit

    assign wr_fire = psel_i && penable_i && pwrite_i && pready_o;
    assign rd_fire = psel_i && penable_i && !pwrite_i && pready_o;
    assign wbyte = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;
    assign mapped = addr_hit(paddr_i, PFDC_ADDR_FIFO_CONTROL) || addr_hit(paddr_i, PFDC_ADDR_CHANNEL_RESET)
        || addr_hit(paddr_i, PFDC_ADDR_AUX_CONTROL) || addr_hit(paddr_i, PFDC_ADDR_FIFO_QUANTITY)
        || addr_hit(paddr_i, PFDC_ADDR_FIFO_THRESHOLD) || addr_hit(paddr_i, PFDC_ADDR_STATUS);
    // command x81 from either serial channel is a device hard reset for this register
    assign hard_clear = channel_command_valid_i && (channel_command_i == PFDC_CMD_HARD_RESET);
    // parallel channel logic runs under soft reset as well as the pin reset
    assign chan_rst = !nrst_i || channel_reset_q[PFDC_BIT_SOFT_RESET];

    // two wait states: answer on the third access cycle keeps decode off the pready path
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            setup_q <= 1'b0;
        else
            setup_q <= psel_i && penable_i && !setup_q;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            pready_o <= 1'b0;
        else
            pready_o <= psel_i && penable_i && !pready_o && setup_q;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            pslverr_o <= 1'b0;
        else
            pslverr_o <= psel_i && penable_i && !pready_o && setup_q && !mapped;
    end

    // ************************************************************
    // registers
    // ************************************************************
    // channel reset register is only in this (channel 0) set, at 6C
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            channel_reset_q <= PFDC_RST_CHANNEL_RESET;
        else if (wr_fire && addr_hit(paddr_i, PFDC_ADDR_CHANNEL_RESET))
            channel_reset_q <= wbyte & PFDC_MASK_CHANNEL_RESET;
    end

    // a write that clears flush ends the fifo reset; flush and direction land together
    always_ff @(posedge clk_sys_i)
    begin
        if (chan_rst || hard_clear)
            fifo_control_q <= PFDC_RST_FIFO_CONTROL;
        else if (wr_fire && addr_hit(paddr_i, PFDC_ADDR_FIFO_CONTROL))
            fifo_control_q <= wbyte;
    end

    // aux control is serial-wide, so soft reset leaves it alone
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            aux_control_q <= PFDC_RST_AUX_CONTROL;
        else if (wr_fire && addr_hit(paddr_i, PFDC_ADDR_AUX_CONTROL))
            aux_control_q <= wbyte & PFDC_MASK_AUX_CONTROL;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (chan_rst)
            threshold_q <= PFDC_RST_THRESHOLD;
        else if (wr_fire && addr_hit(paddr_i, PFDC_ADDR_FIFO_THRESHOLD))
            threshold_q <= wbyte[6:0];
    end

    // quantity reads zero while flushing, since the fifo is empty then
    always_ff @(posedge clk_sys_i)
    begin
        if (chan_rst || fifo_control_q[PFDC_BIT_FIFO_FLUSH])
            quantity_q <= 7'h00;
        else
            quantity_q <= fifo_level_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            prdata_o <= 32'h00000000;
        else if (psel_i && penable_i && !pwrite_i && setup_q && !pready_o)
        begin
            if (addr_hit(paddr_i, PFDC_ADDR_FIFO_CONTROL))
                prdata_o <= {24'h000000, fifo_control_q};
            else if (addr_hit(paddr_i, PFDC_ADDR_CHANNEL_RESET))
                prdata_o <= {24'h000000, channel_reset_q};
            else if (addr_hit(paddr_i, PFDC_ADDR_AUX_CONTROL))
                prdata_o <= {24'h000000, aux_control_q};
            else if (addr_hit(paddr_i, PFDC_ADDR_FIFO_QUANTITY))
                prdata_o <= {25'h0000000, quantity_q};
            else if (addr_hit(paddr_i, PFDC_ADDR_FIFO_THRESHOLD))
                prdata_o <= {25'h0000000, threshold_q};
            else if (addr_hit(paddr_i, PFDC_ADDR_STATUS))
                prdata_o <= {28'h0000000, !transfer_request_n_o, transfer_grant_o, serial_svc_req_n_o};
            else
                prdata_o <= 32'h00000000;
        end
        else if (rd_fire)
            prdata_o <= prdata_o;
    end

    // ************************************************************
    // grant synchroniser and request
    // ************************************************************
    // three stages; first stage feeds only the second
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            grant_sync_q <= 3'b111;
        else
            grant_sync_q <= {grant_sync_q[1:0], transfer_grant_n_i};
    end

    // async mode waits for stages 2 and 3 to agree, costing three cycles of latency
    always_comb
    begin
        if (aux_control_q[PFDC_BIT_ACK_SYNC])
            grant_d = (grant_sync_q[2] == grant_sync_q[1]) ? !grant_sync_q[2] : transfer_grant_o;
        else
            grant_d = !transfer_grant_n_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (chan_rst)
            transfer_grant_o <= 1'b0;
        else
            transfer_grant_o <= grant_d;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (chan_rst)
            transfer_direction_o <= 1'b0;
        else
            transfer_direction_o <= fifo_control_q[PFDC_BIT_DIRECTION];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (chan_rst)
            fifo_flush_o <= 1'b1;
        else
            fifo_flush_o <= fifo_control_q[PFDC_BIT_FIFO_FLUSH];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            channel_reset_o <= 1'b0;
        else
            channel_reset_o <= channel_reset_q[PFDC_BIT_SOFT_RESET];
    end

    // receive needs a whole word present; transmit trusts the threshold to leave room for a word
    // limitation: a threshold above 62 lets a transmit request stand with only one byte free
    always_ff @(posedge clk_sys_i)
    begin
        if (chan_rst)
            transfer_request_n_o <= 1'b1;
        else if (!fifo_control_q[PFDC_BIT_REQ_ENABLE] || fifo_control_q[PFDC_BIT_FIFO_FLUSH])
            transfer_request_n_o <= 1'b1;
        else if (fifo_control_q[PFDC_BIT_DIRECTION])
            transfer_request_n_o <= !(quantity_q <= threshold_q);
        else
            transfer_request_n_o <= !(quantity_q >= threshold_q && quantity_q >= PFDC_WORD_BYTES);
    end

    // ************************************************************
    // serial fair-share override
    // ************************************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            line0_sync_q <= 3'b111;
            line1_sync_q <= 3'b111;
        end
        else
        begin
            line0_sync_q <= {line0_sync_q[1:0], serial_svc_line_n_i[0]};
            line1_sync_q <= {line1_sync_q[1:0], serial_svc_line_n_i[1]};
        end
    end

    // a line's state changes only once both later stages agree, so a one-cycle glitch never counts
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            line_busy_q <= 2'b00;
        else
        begin
            if (line0_sync_q[2] == line0_sync_q[1])
                line_busy_q[0] <= !line0_sync_q[2];
            if (line1_sync_q[2] == line1_sync_q[1])
                line_busy_q[1] <= !line1_sync_q[2];
        end
    end

    // serial channels 2 and 3 only; untouched by parallel soft reset
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_fair
            always_ff @(posedge clk_sys_i)
            begin
                if (!nrst_i)
                    serial_svc_req_n_o[gi] <= 1'b1;
                else if (!serial_svc_pending_i[gi])
                    serial_svc_req_n_o[gi] <= 1'b1;
                else if (aux_control_q[PFDC_BIT_UNFAIR])
                    serial_svc_req_n_o[gi] <= 1'b0;
                else if (serial_svc_req_n_o[gi] && line_busy_q[gi])
                    serial_svc_req_n_o[gi] <= 1'b1;
                else
                    serial_svc_req_n_o[gi] <= 1'b0;
            end
        end
    endgenerate
endmodule : pfdc_top

// ### dv/pfdc_chk.sv
// checker: port-level assertions of the parallel fifo dma control block
`timescale 1ns/10ps
module pfdc_chk
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [6:0] fifo_level_i,
    input wire logic transfer_grant_n_i,
    input wire logic [1:0] serial_svc_pending_i,
    input wire logic [1:0] serial_svc_line_n_i,
    input wire logic transfer_request_n_o,
    input wire logic transfer_grant_o,
    input wire logic transfer_direction_o,
    input wire logic fifo_flush_o,
    input wire logic channel_reset_o,
    input wire logic [1:0] serial_svc_req_n_o
);
    import pfdc_pkg::*;
    logic [1:0] aux_q;
    // ************************************************************
    // aux mirror: sync and override modes are not visible at the ports
    // ************************************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            aux_q <= 2'h0;
        else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == {22'h0, PFDC_ADDR_AUX_CONTROL})
            aux_q <= pstrb_i[0] ? pwdata_i[1:0] : 2'h0;
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    sequence apb_setup;
        psel_i && !penable_i;
    endsequence
    sequence apb_access;
        psel_i && penable_i;
    endsequence
    apb_wait_a: assert property (apb_setup ##1 apb_access |-> !pready_o ##1 !pready_o ##1 pready_o)
        else $error("apb wait wrong");
    ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready too long");
    slverr_ready_a: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
    reset_out_a: assert property ($rose(nrst_i) |-> transfer_request_n_o && serial_svc_req_n_o == 2'h3)
        else $error("outputs not reset");
    flush_blocks_a: assert property (fifo_flush_o [*2] |-> transfer_request_n_o) else $error("request in flush");
    soft_reset_a: assert property (channel_reset_o [*2] |-> fifo_flush_o && !transfer_direction_o)
        else $error("soft reset not held");
    whole_word_a: assert property (!transfer_request_n_o && !transfer_direction_o |->
        $past(fifo_level_i, 2) >= PFDC_WORD_BYTES) else $error("request below a word");
    grant_direct_a: assert property (!aux_q[1] [*2] |-> transfer_grant_o == !$past(transfer_grant_n_i))
        else $error("direct grant wrong");
    grant_sync_a: assert property (aux_q[1] [*2] |->
        (($past(transfer_grant_n_i, 4) != $past(transfer_grant_n_i, 3)) ? transfer_grant_o == $past(transfer_grant_o)
        : transfer_grant_o == !$past(transfer_grant_n_i, 4))) else $error("synced grant wrong");
    svc_unfair_a: assert property (aux_q[0] && serial_svc_pending_i[1] |=> !serial_svc_req_n_o[1])
        else $error("override ignored");
    svc_idle_a: assert property ((serial_svc_pending_i[0] && serial_svc_line_n_i[0]) [*5] |=>
        !serial_svc_req_n_o[0]) else $error("service request missing");
endmodule : pfdc_chk
bind pfdc_top pfdc_chk u_pfdc_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .fifo_level_i(fifo_level_i), .transfer_grant_n_i(transfer_grant_n_i),
    .serial_svc_pending_i(serial_svc_pending_i), .serial_svc_line_n_i(serial_svc_line_n_i),
    .transfer_request_n_o(transfer_request_n_o), .transfer_grant_o(transfer_grant_o),
    .transfer_direction_o(transfer_direction_o), .fifo_flush_o(fifo_flush_o), .channel_reset_o(channel_reset_o),
    .serial_svc_req_n_o(serial_svc_req_n_o));

// ### dv/pfdc_dma_model.sv
// partner: behavioural dma controller answering requests with grant pulses
`timescale 1ns/10ps
module pfdc_dma_model
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic enable_i,
    input wire logic slow_i,
    input wire logic transfer_request_n_i,
    output logic transfer_grant_n_o
);
    logic [2:0] wait_q;
    logic again_q;
    // slow mode holds grants back so the request stands several cycles unanswered,
    // then keeps the grant low two cycles so the synchronised path sees it settle
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || !enable_i || transfer_request_n_i || (!transfer_grant_n_o && !again_q))
            transfer_grant_n_o <= 1'b1;
        else if (wait_q >= (slow_i ? 3'h5 : 3'h0))
            transfer_grant_n_o <= 1'b0;
        wait_q <= (!nrst_i || transfer_request_n_i || !transfer_grant_n_o) ? 3'h0 : wait_q + 3'h1;
        again_q <= nrst_i && enable_i && slow_i && transfer_grant_n_o && !transfer_request_n_i && (wait_q >= 3'h5);
    end
endmodule : pfdc_dma_model

// ### dv/pfdc_test.sv
// testbench: registers, request thresholds, flush, soft reset, grant and service requests
`timescale 1ns/10ps
module pfdc_test;
    import pfdc_pkg::*;
    logic clk_sys_i, nrst_i, psel, penable, pwrite, cmd_valid, grant_n, req_n, grant, dir, flush, chan_rst;
    logic dma_en, dma_slow, pready, pslverr, tx;
    logic [31:0] paddr, pwdata, prdata;
    logic [7:0] cmd;
    logic [6:0] level, thr, lvl;
    logic [1:0] pending, line_n, svc_req_n;
    int fail_count, checks_done;
    pfdc_top u_pfdc_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .fifo_level_i(level), .channel_command_i(cmd),
        .channel_command_valid_i(cmd_valid), .transfer_grant_n_i(grant_n), .serial_svc_pending_i(pending),
        .serial_svc_line_n_i(line_n), .transfer_request_n_o(req_n), .transfer_grant_o(grant),
        .transfer_direction_o(dir), .fifo_flush_o(flush), .channel_reset_o(chan_rst), .serial_svc_req_n_o(svc_req_n));
    pfdc_dma_model u_pfdc_dma_model (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .enable_i(dma_en),
        .slow_i(dma_slow), .transfer_request_n_i(req_n), .transfer_grant_n_o(grant_n));
    function automatic logic exp_req_n(input logic t, input logic [6:0] q, input logic [6:0] h);
        return t ? !(q <= h) : !(q >= h && q >= PFDC_WORD_BYTES);
    endfunction : exp_req_n
    task conclude;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick
    // one apb transfer; a read compares its data, every transfer its error flag
    task apb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [7:0] exp, input logic err);
        int n;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, a};
        pwdata <= {24'h0, d};
        @(posedge clk_sys_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (pready !== 1'b1 && n < 8);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fail_count++;
            conclude();
        end
        else
        begin
            chk({31'h0, pslverr}, {31'h0, err});
            if (!w)
                chk(prdata, {24'h0, exp});
        end
    endtask : apb
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        {nrst_i, psel, penable, pwrite, cmd_valid, dma_en, dma_slow} = 7'h0;
        {paddr, pwdata, cmd, level, pending, line_n} = 83'h3;
        fail_count = 0;
        checks_done = 0;
        void'($urandom(89392));
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        apb(0, PFDC_ADDR_FIFO_CONTROL, 8'h0, PFDC_RST_FIFO_CONTROL, 0);
        apb(0, PFDC_ADDR_CHANNEL_RESET, 8'h0, PFDC_RST_CHANNEL_RESET, 0);
        apb(0, PFDC_ADDR_AUX_CONTROL, 8'h0, PFDC_RST_AUX_CONTROL, 0);
        apb(0, 10'h010, 8'h0, 8'h0, 1);
        apb(1, PFDC_ADDR_AUX_CONTROL, 8'hFF, 8'h0, 0);
        apb(1, PFDC_ADDR_CHANNEL_RESET, 8'hFF, 8'h0, 0);
        tick(2);
        chk({30'h0, chan_rst, flush}, 32'h3);
        apb(0, PFDC_ADDR_CHANNEL_RESET, 8'h0, 8'h01, 0);
        apb(0, PFDC_ADDR_AUX_CONTROL, 8'h0, 8'hFB, 0);
        apb(1, PFDC_ADDR_CHANNEL_RESET, 8'h00, 8'h0, 0);
        apb(1, PFDC_ADDR_FIFO_CONTROL, 8'hA0, 8'h0, 0);
        tick(12);
        chk({29'h0, flush, dir, req_n}, 32'h7);
        apb(1, PFDC_ADDR_FIFO_CONTROL, 8'h20, 8'h0, 0);
        tick(2);
        chk({29'h0, flush, dir, req_n}, 32'h3);
        apb(1, PFDC_ADDR_AUX_CONTROL, 8'h00, 8'h0, 0);
        dma_en <= 1'b1;
        for (int r = 0; r < 12; r++)
        begin
            tx = r[0];
            thr = (r == 0) ? 7'h00 : 7'($urandom % 65);
            dma_slow <= 1'($urandom);
            if (r == 6)
                apb(1, PFDC_ADDR_AUX_CONTROL, 8'h03, 8'h0, 0);
            apb(1, PFDC_ADDR_FIFO_THRESHOLD, {1'b0, thr}, 8'h0, 0);
            apb(1, PFDC_ADDR_FIFO_CONTROL, {2'h2, tx, 5'h0}, 8'h0, 0);
            apb(1, PFDC_ADDR_FIFO_CONTROL, {2'h1, tx, 5'h0}, 8'h0, 0);
            for (int k = 0; k < 8; k++)
            begin
                lvl = (k < 3) ? thr + 7'(k) - 7'h1 : (k == 3) ? 7'h01 : 7'($urandom % 65);
                lvl = (lvl > 7'h40) ? 7'h00 : lvl;
                @(posedge clk_sys_i);
                level <= lvl;
                tick(3);
                chk({31'h0, req_n}, {31'h0, exp_req_n(tx, lvl, thr)});
            end
            apb(0, PFDC_ADDR_FIFO_QUANTITY, 8'h0, {1'b0, lvl}, 0);
            apb(0, PFDC_ADDR_FIFO_THRESHOLD, 8'h0, {1'b0, thr}, 0);
        end
        dma_en <= 1'b0;
        apb(1, PFDC_ADDR_FIFO_CONTROL, 8'hC0, 8'h0, 0);
        tick(3);
        chk({31'h0, req_n}, 32'h1);
        apb(0, PFDC_ADDR_FIFO_QUANTITY, 8'h0, 8'h00, 0);
        for (int c = 0; c < 2; c++)
        begin
            @(posedge clk_sys_i);
            cmd <= 8'h80 + 8'(c);
            cmd_valid <= 1'b1;
            @(posedge clk_sys_i);
            cmd_valid <= 1'b0;
            apb(0, PFDC_ADDR_FIFO_CONTROL, 8'h0, (c == 1) ? PFDC_RST_FIFO_CONTROL : 8'hC0, 0);
        end
        for (int i = 0; i < 40; i++)
        begin
            if (i == 20)
                apb(1, PFDC_ADDR_AUX_CONTROL, 8'h00, 8'h0, 0);
            @(posedge clk_sys_i);
            pending <= 2'($urandom);
            line_n <= ($urandom % 4 != 0) ? 2'h3 : 2'($urandom);
            tick(6);
        end
        conclude();
    end
endmodule : pfdc_test
